// ==== logic/alsm_pkg.sv ====
package alsm_pkg;

  // ==========================================================
  // geometry
  localparam int N_CH = 4;
  localparam int N_SMP = 8;
  localparam int SMP_W = 9;
  localparam int N_LANES = 8;
  localparam int LANE_W = 40;

  // ==========================================================
  // link mode codes handled here
  localparam logic [3:0] MODE_4 = 4'h4;
  localparam logic [3:0] MODE_5 = 4'h5;
  localparam logic [3:0] MODE_6 = 4'h6;
  localparam logic [3:0] MODE_7 = 4'h7;
  localparam logic [3:0] MODE_8 = 4'h8;
  localparam logic [3:0] MODE_9 = 4'h9;
  localparam logic [3:0] MODE_10 = 4'ha;

  // ==========================================================
  // fill and reset values
  localparam logic [7:0] ZERO_OCTET = 8'h00;
  localparam logic [3:0] ZERO_NIBBLE = 4'h0;
  localparam logic [2:0] PAD3 = 3'h0;
  localparam logic PAD1 = 1'h0;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [2:0] RST_OCTETS = 3'h0;
  localparam logic [3:0] RST_MODE = 4'h0;
  localparam logic [1:0] RST_PART = 2'h0;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    PART_SINGLE = 2'h0,
    PART_DUAL = 2'h1,
    PART_QUAD = 2'h2
  } alsm_part_e;

  typedef struct packed {
    logic [N_CH-1:0][N_SMP-1:0][SMP_W-1:0] smp;
  } alsm_frame_s;

  typedef struct packed {
    logic [N_LANES-1:0][LANE_W-1:0] lane;
  } alsm_lanes_s;

  typedef struct packed {
    logic [N_LANES-1:0] mask;
    logic [2:0] octets;
    logic err;
  } alsm_lcfg_s;

  // ==========================================================
  // sample field helpers
  function automatic logic [11:0] pad12(input logic [SMP_W-1:0] s);
    return {s, PAD3};
  endfunction

  function automatic logic [9:0] pad10(input logic [SMP_W-1:0] s);
    return {s, PAD1};
  endfunction

  function automatic logic [7:0] top8(input logic [SMP_W-1:0] s);
    return s[8:1];
  endfunction

endpackage

// ==== logic/alsm_frame_capture.sv ====
`timescale 1ns/1ps
module alsm_frame_capture
  import alsm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // sample side
  input wire logic in_valid,
  input alsm_frame_s in_frame,
  // mapper side
  output logic out_valid,
  output alsm_frame_s out_frame
);

  typedef struct packed {
    logic valid;
    alsm_frame_s frame;
  } alsm_cap_s;

  alsm_cap_s st_reg;
  alsm_cap_s st_next;

  // ==========================================================
  // hold a frame one cycle so the mapper sees stable samples
  always_comb begin
    st_next = st_reg;
    st_next.valid = in_valid;
    if (in_valid) begin
      st_next.frame = in_frame;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_valid = st_reg.valid;
  assign out_frame = st_reg.frame;

endmodule

// ==== logic/alsm_lane_config.sv ====
`timescale 1ns/1ps
module alsm_lane_config
  import alsm_pkg::*;
(
  // selected link
  input wire logic [3:0] mode,
  input wire logic [1:0] part,
  // lane plan
  output alsm_lcfg_s cfg
);

  // ==========================================================
  // lanes used: quad count, halved and rounded up for dual, single as listed
  function automatic logic [7:0] first_n(input int n);
    logic [7:0] m;
    m = '0;
    for (int i = 0; i < N_LANES; i++) begin
      m[i] = (i < n);
    end
    return m;
  endfunction

  always_comb begin
    int nq;
    int nd;
    int ns;
    nq = 0;
    nd = 0;
    ns = 0;
    cfg = '{mask: RST_MASK, octets: RST_OCTETS, err: 1'b0};
    unique case (mode)
      MODE_4: begin
        nq = 3; nd = 2; ns = 1; cfg.octets = 3'h2;
      end
      MODE_5: begin
        nq = 2; nd = 1; ns = 1; cfg.octets = 3'h2;
      end
      MODE_6: begin
        nq = 6; nd = 3; ns = 2; cfg.octets = 3'h2;
      end
      MODE_7: begin
        nq = 4; nd = 2; ns = 1; cfg.octets = 3'h1;
      end
      MODE_8: begin
        nq = 4; nd = 2; ns = 1; cfg.octets = 3'h3;
      end
      MODE_9: begin
        nq = 8; nd = 4; ns = 2; cfg.octets = 3'h1;
      end
      MODE_10: begin
        nq = 8; nd = 4; ns = 2; cfg.octets = 3'h5;
      end
      default: begin
        cfg.err = 1'b1;
      end
    endcase
    // dual and single parts drive only the low lanes
    unique case (part)
      PART_QUAD: cfg.mask = first_n(nq);
      PART_DUAL: cfg.mask = first_n(nd);
      PART_SINGLE: cfg.mask = first_n(ns);
      default: cfg.err = 1'b1;
    endcase
    if (cfg.err) begin
      cfg.mask = RST_MASK;
      cfg.octets = RST_OCTETS;
    end
  end

endmodule

// ==== logic/alsm_mapper.sv ====
`timescale 1ns/1ps
module alsm_mapper
  import alsm_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // configuration, sampled only while streaming is off
  input wire logic STREAM_EN,
  input wire logic [3:0] LINK_MODE_SELECT,
  input wire logic [1:0] PART_CHANNELS,
  // converter samples
  input wire logic SAMPLE_VALID,
  input alsm_frame_s SAMPLES,
  // lane side
  output alsm_lanes_s LANE_DATA,
  output logic [7:0] LANE_ACTIVE,
  output logic [2:0] LANE_OCTETS,
  output logic LANE_VALID,
  output logic MODE_ERR
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } alsm_state_e;

  typedef struct packed {
    alsm_state_e fsm;
    logic [3:0] mode;
    logic [1:0] part;
    alsm_lcfg_s cfg;
    alsm_lanes_s lanes;
    logic valid;
  } alsm_st_s;

  alsm_st_s st_reg;
  alsm_st_s st_next;

  logic cap_valid;
  alsm_frame_s cap_frame;
  alsm_lcfg_s new_cfg;

  // ==========================================================
  // submodules
  alsm_frame_capture u_capture (
    .clk(MCLK),
    .rst(RST),
    .in_valid(SAMPLE_VALID),
    .in_frame(SAMPLES),
    .out_valid(cap_valid),
    .out_frame(cap_frame)
  );

  // plan follows the live selection so it is ready at the start edge
  alsm_lane_config u_lane_cfg (
    .mode(LINK_MODE_SELECT),
    .part(PART_CHANNELS),
    .cfg(new_cfg)
  );

  // ==========================================================
  // packing; each lane word is left justified, octet 0 at [39:32]
  function automatic logic [39:0] left(input logic [39:0] v, input int bits);
    return v << (LANE_W - bits);
  endfunction

  // a sample the part does not have reads as zero
  function automatic logic [SMP_W-1:0] keep(input logic [SMP_W-1:0] s, input logic on);
    return on ? s : '0;
  endfunction

  // ==========================================================
  // three-lane group shared by modes 4 and 6: padded s0 and s1[8:5],
  // then s1[4:0] padded and s2[8:1], then s2[0] padded and padded s3
  typedef logic [2:0][LANE_W-1:0] alsm_trio_t;

  function automatic alsm_trio_t pack_trio(
    input logic [SMP_W-1:0] s0,
    input logic [SMP_W-1:0] s1,
    input logic [SMP_W-1:0] s2,
    input logic [SMP_W-1:0] s3
  );
    alsm_trio_t t;
    t[0] = left(40'({pad12(s0), s1[8:5]}), 16);
    t[1] = left(40'({s1[4:0], PAD3, s2[8:1]}), 16);
    t[2] = left(40'({s2[0], PAD3, pad12(s3)}), 16);
    return t;
  endfunction

  // ==========================================================
  // 9-bit modes with two octets per lane

  // mode 4: one trio for the first sample of every channel;
  // a single part has no B and a dual part no C, so those read zero
  function automatic alsm_lanes_s pack_m4(input logic [1:0] part, input alsm_frame_s f);
    alsm_lanes_s o;
    alsm_trio_t t;
    logic has_b;
    logic has_c;
    o = '0;
    has_b = (part != PART_SINGLE);
    has_c = (part == PART_QUAD);
    t = pack_trio(f.smp[0][0], keep(f.smp[1][0], has_b), keep(f.smp[2][0], has_c),
                  f.smp[3][0]);
    o.lane[0] = t[0];
    o.lane[1] = t[1];
    o.lane[2] = t[2];
    return o;
  endfunction

  // mode 6: two samples per channel, one trio per channel pair;
  // the C and D group is quad only and the lane mask blanks it elsewhere
  function automatic alsm_lanes_s pack_m6(input logic [1:0] part, input alsm_frame_s f);
    alsm_lanes_s o;
    alsm_trio_t t;
    logic has_b;
    o = '0;
    has_b = (part != PART_SINGLE);
    for (int g = 0; g < 2; g++) begin
      t = pack_trio(f.smp[2*g][0], f.smp[2*g][1], keep(f.smp[2*g+1][0], has_b || g == 1),
                    f.smp[2*g+1][1]);
      o.lane[3*g] = t[0];
      o.lane[3*g+1] = t[1];
      o.lane[3*g+2] = t[2];
    end
    return o;
  endfunction

  // ==========================================================
  // 8-bit modes keep the upper eight bits of each sample

  // mode 5: two channels per lane, one octet each;
  // lane 1 is quad only and the lane mask blanks it on other parts
  function automatic alsm_lanes_s pack_m5(input logic [1:0] part, input alsm_frame_s f);
    alsm_lanes_s o;
    logic has_b;
    o = '0;
    has_b = (part != PART_SINGLE);
    o.lane[0] = left(40'({top8(f.smp[0][0]),
                  has_b ? top8(f.smp[1][0]) : ZERO_OCTET}), 16);
    o.lane[1] = left(40'({top8(f.smp[2][0]), top8(f.smp[3][0])}), 16);
    return o;
  endfunction

  // mode 7: one octet per lane, one lane per channel
  function automatic alsm_lanes_s pack_m7(input alsm_frame_s f);
    alsm_lanes_s o;
    o = '0;
    for (int c = 0; c < N_CH; c++) begin
      o.lane[c] = left(40'(top8(f.smp[c][0])), 8);
    end
    return o;
  endfunction

  // mode 9: two lanes per channel, one octet each;
  // the even sample takes the lower lane of the pair
  function automatic alsm_lanes_s pack_m9(input alsm_frame_s f);
    alsm_lanes_s o;
    o = '0;
    for (int c = 0; c < N_CH; c++) begin
      o.lane[2*c] = left(40'(top8(f.smp[c][0])), 8);
      o.lane[2*c+1] = left(40'(top8(f.smp[c][1])), 8);
    end
    return o;
  endfunction

  // ==========================================================
  // modes that carry several samples of one channel per lane

  // mode 8: one lane per channel, two 12-bit fields, earlier first
  function automatic alsm_lanes_s pack_m8(input alsm_frame_s f);
    alsm_lanes_s o;
    o = '0;
    for (int c = 0; c < N_CH; c++) begin
      o.lane[c] = left(40'({pad12(f.smp[c][0]), pad12(f.smp[c][1])}), 24);
    end
    return o;
  endfunction

  // mode 10: two lanes per channel, lower lane even samples, upper odd;
  // four 10-bit fields fill the 40-bit word exactly
  function automatic alsm_lanes_s pack_m10(input alsm_frame_s f);
    alsm_lanes_s o;
    o = '0;
    for (int c = 0; c < N_CH; c++) begin
      for (int h = 0; h < 2; h++) begin
        o.lane[2*c+h] = {pad10(f.smp[c][h]), pad10(f.smp[c][h+2]),
                         pad10(f.smp[c][h+4]), pad10(f.smp[c][h+6])};
      end
    end
    return o;
  endfunction

  // ==========================================================
  // mode dispatch; a code outside 4 to 10 never reaches streaming,
  // the default only keeps the function total
  function automatic alsm_lanes_s map_frame(
    input logic [3:0] mode,
    input logic [1:0] part,
    input alsm_frame_s f
  );
    alsm_lanes_s o;
    o = '0;
    unique case (mode)
      MODE_4: begin
        o = pack_m4(part, f);
      end
      MODE_5: begin
        o = pack_m5(part, f);
      end
      MODE_6: begin
        o = pack_m6(part, f);
      end
      MODE_7: begin
        o = pack_m7(f);
      end
      MODE_8: begin
        o = pack_m8(f);
      end
      MODE_9: begin
        o = pack_m9(f);
      end
      MODE_10: begin
        o = pack_m10(f);
      end
      default: begin
        o = '0;
      end
    endcase
    return o;
  endfunction

  // blank every lane the part does not drive
  function automatic alsm_lanes_s gate(input alsm_lanes_s l, input logic [7:0] m);
    alsm_lanes_s o;
    o = '0;
    for (int i = 0; i < N_LANES; i++) begin
      o.lane[i] = m[i] ? l.lane[i] : '0;
    end
    return o;
  endfunction

  // ==========================================================
  // control
  always_comb begin
    st_next = st_reg;
    st_next.valid = 1'b0;
    unique case (st_reg.fsm)
      ST_IDLE: begin
        // selection only moves while no data flows; the receiver
        // cannot tell the packing apart from lane contents
        st_next.mode = LINK_MODE_SELECT;
        st_next.part = PART_CHANNELS;
        st_next.cfg = new_cfg;
        st_next.lanes = '0;
        if (STREAM_EN && !new_cfg.err) begin
          st_next.fsm = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!STREAM_EN) begin
          st_next.fsm = ST_IDLE;
          st_next.lanes = '0;
        end else if (cap_valid) begin
          st_next.lanes = gate(map_frame(st_reg.mode, st_reg.part, cap_frame),
                               st_reg.cfg.mask);
          st_next.valid = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      st_reg <= '{fsm: ST_IDLE, mode: RST_MODE, part: RST_PART,
                  cfg: '{mask: RST_MASK, octets: RST_OCTETS, err: 1'b0},
                  lanes: '0, valid: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs, all straight from the state register
  assign LANE_DATA = st_reg.lanes;
  assign LANE_ACTIVE = st_reg.cfg.mask;
  assign LANE_OCTETS = st_reg.cfg.octets;
  assign LANE_VALID = st_reg.valid;
  assign MODE_ERR = st_reg.cfg.err;

endmodule

// ==== tb/alsm_properties.sv ====
`timescale 1ns/1ps
module alsm_properties
  import alsm_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // inputs
  input wire logic STREAM_EN,
  input wire logic [3:0] LINK_MODE_SELECT,
  input wire logic [1:0] PART_CHANNELS,
  input wire logic SAMPLE_VALID,
  input alsm_frame_s SAMPLES,
  // outputs
  input alsm_lanes_s LANE_DATA,
  input wire logic [7:0] LANE_ACTIVE,
  input wire logic [2:0] LANE_OCTETS,
  input wire logic LANE_VALID,
  input wire logic MODE_ERR
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  logic stray;
  always_comb begin
    stray = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (!LANE_ACTIVE[i] && LANE_DATA.lane[i] != '0) stray = 1'b1;
    end
  end
  // ====
  // framing
  property p_lat; LANE_VALID |-> $past(SAMPLE_VALID, 2); endproperty
  a_lat: assert property (p_lat) else $error("lane frame without sample frame");
  property p_drop; SAMPLE_VALID ##1 !STREAM_EN |=> !LANE_VALID; endproperty
  a_drop: assert property (p_drop) else $error("idle frame was sent");
  property p_hold; STREAM_EN [*3] |-> $stable(LANE_ACTIVE); endproperty
  a_hold: assert property (p_hold) else $error("lane plan moved while streaming");
  property p_err; MODE_ERR |-> LANE_ACTIVE == 8'h00 && LANE_OCTETS == 3'h0 && !LANE_VALID;
  endproperty
  a_err: assert property (p_err) else $error("refused selection drives lanes");
  property p_trk;
    !STREAM_EN && PART_CHANNELS == 2'h3 ##1 !STREAM_EN && PART_CHANNELS == 2'h3 |=> MODE_ERR;
  endproperty
  a_trk: assert property (p_trk) else $error("bad part not flagged");
  // ====
  // lane content
  property p_stray; LANE_VALID |-> !stray; endproperty
  a_stray: assert property (p_stray) else $error("unused lane not zero");
  property p_oct1;
    LANE_VALID && LANE_OCTETS == 3'h1 |->
      LANE_DATA.lane[0] == {$past(SAMPLES.smp[0][0][8:1], 2), 32'h0};
  endproperty
  a_oct1: assert property (p_oct1) else $error("one-octet lane wrong");
  property p_oct2;
    LANE_VALID && LANE_OCTETS == 3'h2 |-> LANE_DATA.lane[0][23:0] == 24'h0 &&
      LANE_DATA.lane[0][39:32] == $past(SAMPLES.smp[0][0][8:1], 2);
  endproperty
  a_oct2: assert property (p_oct2) else $error("two-octet lane wrong");
  property p_oct3;
    LANE_VALID && LANE_OCTETS == 3'h3 |-> LANE_DATA.lane[0] ==
      {$past(SAMPLES.smp[0][0], 2), 3'h0, $past(SAMPLES.smp[0][1], 2), 3'h0, 16'h0};
  endproperty
  a_oct3: assert property (p_oct3) else $error("three-octet lane wrong");
  property p_oct5;
    LANE_VALID && LANE_OCTETS == 3'h5 |->
      LANE_DATA.lane[1][39:30] == {$past(SAMPLES.smp[0][1], 2), 1'b0} &&
      LANE_DATA.lane[0][9:0] == {$past(SAMPLES.smp[0][6], 2), 1'b0};
  endproperty
  a_oct5: assert property (p_oct5) else $error("five-octet lane wrong");
endmodule

bind alsm_mapper alsm_properties chk_i (.MCLK(MCLK), .RST(RST), .STREAM_EN(STREAM_EN),
  .LINK_MODE_SELECT(LINK_MODE_SELECT), .PART_CHANNELS(PART_CHANNELS),
  .SAMPLE_VALID(SAMPLE_VALID), .SAMPLES(SAMPLES), .LANE_DATA(LANE_DATA),
  .LANE_ACTIVE(LANE_ACTIVE), .LANE_OCTETS(LANE_OCTETS), .LANE_VALID(LANE_VALID),
  .MODE_ERR(MODE_ERR));

// ==== tb/alsm_rx_model.sv ====
`timescale 1ns/1ps
module alsm_rx_model
  import alsm_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // lanes
  input alsm_lanes_s LANE_DATA,
  input wire logic [7:0] LANE_ACTIVE,
  input wire logic LANE_VALID,
  // status
  output int frames,
  output logic bad
);
  // a receiver cannot tell an idle lane from data, so idle lanes must read zero
  always @(posedge MCLK) begin
    if (RST) begin
      frames <= 0;
      bad <= 1'b0;
    end else if (LANE_VALID) begin
      frames <= frames + 1;
      for (int i = 0; i < 8; i++) begin
        if (!LANE_ACTIVE[i] && LANE_DATA.lane[i] != '0) bad <= 1'b1;
      end
    end
  end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
  import alsm_pkg::*;
  logic MCLK = 0;
  logic RST = 1;
  logic STREAM_EN = 0;
  logic SAMPLE_VALID = 0;
  logic [3:0] LINK_MODE_SELECT = 4'h4;
  logic [1:0] PART_CHANNELS = 2'h0;
  alsm_frame_s SAMPLES = '0;
  alsm_lanes_s LANE_DATA;
  logic [7:0] LANE_ACTIVE;
  logic [2:0] LANE_OCTETS;
  logic LANE_VALID;
  logic MODE_ERR;
  logic rx_bad;
  int rx_frames;
  int fail_count = 0;
  int checks = 0;
  int seed = 32'hdb6f;
  int cyc = 0;
  int sent = 0;
  alsm_lanes_s q[$];
  int nl[7][3] = '{'{1, 2, 3}, '{1, 1, 2}, '{2, 3, 6}, '{1, 2, 4}, '{1, 2, 4}, '{2, 4, 8},
    '{2, 4, 8}};
  int oc[7] = '{2, 2, 2, 1, 3, 1, 5};

  alsm_mapper uut (.MCLK(MCLK), .RST(RST), .STREAM_EN(STREAM_EN),
    .LINK_MODE_SELECT(LINK_MODE_SELECT), .PART_CHANNELS(PART_CHANNELS),
    .SAMPLE_VALID(SAMPLE_VALID), .SAMPLES(SAMPLES), .LANE_DATA(LANE_DATA),
    .LANE_ACTIVE(LANE_ACTIVE), .LANE_OCTETS(LANE_OCTETS), .LANE_VALID(LANE_VALID),
    .MODE_ERR(MODE_ERR));
  alsm_rx_model rx (.MCLK(MCLK), .RST(RST), .LANE_DATA(LANE_DATA),
    .LANE_ACTIVE(LANE_ACTIVE), .LANE_VALID(LANE_VALID), .frames(rx_frames), .bad(rx_bad));

  initial forever #2.5 MCLK = ~MCLK;

  task chk(input logic [319:0] seen, input logic [319:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %0h, want %0h", $time, seen, exp);
    end
  endtask

  task final_report;
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ====
  // reference packing
  function automatic alsm_lanes_s model(input int m, input int p, input alsm_frame_s f);
    alsm_lanes_s e;
    logic [8:0] y0;
    e = '0;
    case (m)
      4: begin
        e.lane[0] = {f.smp[0][0], 3'h0, (p > 0) ? f.smp[1][0][8:5] : 4'h0, 24'h0};
        e.lane[1] = {f.smp[1][0][4:0], 3'h0, (p == 2) ? f.smp[2][0][8:1] : 8'h00, 24'h0};
        e.lane[2] = {f.smp[2][0][0], 3'h0, f.smp[3][0], 3'h0, 24'h0};
      end
      5: begin
        e.lane[0] = {f.smp[0][0][8:1], (p > 0) ? f.smp[1][0][8:1] : 8'h00, 24'h0};
        e.lane[1] = {f.smp[2][0][8:1], f.smp[3][0][8:1], 24'h0};
      end
      6: for (int g = 0; g < 2; g++) begin
        y0 = (p == 0) ? 9'h0 : f.smp[2*g+1][0];
        e.lane[3*g] = {f.smp[2*g][0], 3'h0, f.smp[2*g][1][8:5], 24'h0};
        e.lane[3*g+1] = {f.smp[2*g][1][4:0], 3'h0, y0[8:1], 24'h0};
        e.lane[3*g+2] = {y0[0], 3'h0, f.smp[2*g+1][1], 3'h0, 24'h0};
      end
      default: for (int c = 0; c < 4; c++) begin
        if (m == 7) e.lane[c] = {f.smp[c][0][8:1], 32'h0};
        if (m == 8) e.lane[c] = {f.smp[c][0], 3'h0, f.smp[c][1], 3'h0, 16'h0};
        for (int k = 0; k < 2; k++) begin
          if (m == 9) e.lane[2*c+k] = {f.smp[c][k][8:1], 32'h0};
          if (m == 10) e.lane[2*c+k] = {f.smp[c][k], 1'b0, f.smp[c][k+2], 1'b0,
            f.smp[c][k+4], 1'b0, f.smp[c][k+6], 1'b0};
        end
      end
    endcase
    for (int i = 0; i < 8; i++) if (i >= nl[m-4][p]) e.lane[i] = '0;
    return e;
  endfunction

  // selection is only moved with streaming off, then streaming is set to en
  task cfg(input int m, input int p, input logic en);
    logic ok;
    ok = m >= 4 && m <= 10 && p < 3;
    STREAM_EN = 0;
    LINK_MODE_SELECT = 4'(m);
    PART_CHANNELS = 2'(p);
    repeat (3) @(negedge MCLK);
    chk(MODE_ERR, !ok);
    chk(LANE_ACTIVE, ok ? 8'((1 << nl[m-4][p]) - 1) : 8'h00);
    chk(LANE_OCTETS, ok ? 3'(oc[m-4]) : 3'h0);
    STREAM_EN = en;
    @(negedge MCLK);
  endtask

  task frames(input int n, input int m, input int p, input logic live);
    alsm_frame_s f;
    for (int j = 0; j < n; j++) begin
      for (int c = 0; c < 4; c++) for (int i = 0; i < 8; i++) f.smp[c][i] = 9'($random(seed));
      SAMPLES = f;
      SAMPLE_VALID = 1;
      if (live) begin
        q.push_back(model(m, p, f));
        sent++;
      end
      @(negedge MCLK);
    end
    SAMPLE_VALID = 0;
    repeat (3) @(negedge MCLK);
  endtask

  always @(negedge MCLK) begin
    cyc++;
    if (LANE_VALID === 1'b1) begin
      if (q.size() == 0) chk(1, 0);
      else chk(LANE_DATA, q.pop_front());
    end
    if (cyc > 3000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    repeat (8) @(negedge MCLK);
    chk(LANE_VALID, 0);
    chk(LANE_DATA, 0);
    RST = 0;
    for (int m = 4; m <= 10; m++) for (int p = 0; p < 3; p++) begin
      cfg(m, p, 1);
      frames(3, m, p, 1);
    end
    // changes while streaming must not retarget the lanes
    LINK_MODE_SELECT = 4'h7;
    PART_CHANNELS = 2'h0;
    repeat (3) @(negedge MCLK);
    chk(LANE_ACTIVE, 8'hff);
    frames(2, 10, 2, 1);
    cfg(5, 2, 0);
    frames(2, 5, 2, 0);
    chk(LANE_DATA, 0);
    cfg(11, 2, 1);
    frames(1, 4, 2, 0);
    cfg(4, 3, 1);
    frames(1, 4, 2, 0);
    chk(rx_frames, sent);
    chk(rx_bad, 0);
    final_report();
  end
endmodule
